// ==== common/cgmc_defs.vh ====
// Operation
// R1: High gain bit selects oscillator amplitude
// R2: Range bit sets prescale 64 or 1
// R3: Range bit accepts first write only
// R4: Range matters only in external modes
// R5: Reference select: clock or crystal
// R6: Reference select is write-once
// R7: Two-bit clock mode select encoding
// R8: Bypassed external waits for reference ready
// R9: Off mode keeps stored mode select
// R10: Mode writes ignored while change pending
// R11: First write 0X blocks later 1X
// R12: Off-mode oscillator off unless special case
// R13: Off-mode enable keeps oscillator in 1X
// R14: Clock loss detection disable bit
// R15: Control one bit zero reads zero
// R16: Internal mode output frequency formula
// R17: Reset default is self-clocked mode
// R18: Lock loss without reset enable interrupts
// R19: Clock loss without reset enable interrupts
// R20: Multiply and divide field positions
// R21: Status one read-only except flag clear
// R22: Trim written only when tuning
// R23: Trim at doubled divider near maximum
// R24: Multiply codes map to 4..18
// R25: Divide codes map to 1..128
// R26: Loss flags held until flag cleared
`ifndef CGMC_DEFS_VH
`define CGMC_DEFS_VH
// Register byte addresses
`define CGMC_ADDR_CTRL1 4'h0
`define CGMC_ADDR_CTRL2 4'h4
`define CGMC_ADDR_STAT1 4'h8
`define CGMC_ADDR_TRIM 4'hC
// Control one fields
`define CGMC_C1_HGO 7
`define CGMC_C1_RANGE 6
`define CGMC_C1_REFERENCE_SOURCE_SELECT 5
`define CGMC_C1_MODE_HI 4
`define CGMC_C1_MODE_LO 3
`define CGMC_C1_OSCEN 2
`define CGMC_C1_CLOCK_LOSS_DETECT_DISABLE 1
// Control two fields
`define CGMC_C2_LOCK_LOSS_RESET_ENABLE 7
`define CGMC_C2_MFD_HI 6
`define CGMC_C2_MFD_LO 4
`define CGMC_C2_CLOCK_LOSS_RESET_ENABLE 3
`define CGMC_C2_RFD_HI 2
`define CGMC_C2_RFD_LO 0
// Status one fields
`define CGMC_S1_REFERENCE_STATUS 5
`define CGMC_S1_LOCK_LOSS_STATUS 4
`define CGMC_S1_LOCK 3
`define CGMC_S1_CLOCK_LOSS_STATUS 2
`define CGMC_S1_EXT_REFERENCE_READY 1
`define CGMC_S1_IF 0
// Clock modes
`define CGMC_MODE_SCM 2'h0
`define CGMC_MODE_FEI 2'h1
`define CGMC_MODE_FBE 2'h2
`define CGMC_MODE_FEE 2'h3
// Reset values and factors
`define CGMC_RST_CTRL1 8'h00
`define CGMC_RST_CTRL2 8'h00
`define CGMC_RST_TRIM 8'h80
`define CGMC_P_LOW 7'h40
`define CGMC_P_HIGH 7'h01
`define CGMC_IRG_DIV 3'h7
// AXI responses
`define CGMC_RESP_OKAY 2'h0
`define CGMC_RESP_SLVERR 2'h2
`endif

// ==== dv/cgmc_ref_osc.sv ====
`timescale 1ns/10ps
`default_nettype none
// ********
// Crystal model with a start-up delay
// ********
module cgmc_ref_osc #(parameter int START_CYCLES = 60) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Oscillator request and ready
   input wire logic osc_req_i,
   output logic ready_o
);
   int count;
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         count <= 0;
         ready_o <= 1'b0;
      end else if (!osc_req_i) begin
         count <= 0;
         ready_o <= 1'b0;
      end else if (count < START_CYCLES) begin
         count <= count + 1;
      end else begin
         ready_o <= 1'b1; // Slow start keeps the bypass wait visible
      end
   end
endmodule
`default_nettype wire

// ==== dv/cgmc_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
// ********
// Checker on generator control outputs
// ********
module cgmc_sva (
   // Clock and reset
   input wire logic CORE_CLK_I,
   input wire logic RST_B_I,
   // Watched status and controls
   input wire logic EXT_REFERENCE_READY_I,
   input wire logic LOCK_LOSS_EVENT_I,
   input wire logic CLOCK_LOSS_EVENT_I,
   input wire logic [1:0] ACTIVE_MODE_O,
   input wire logic OSC_HIGH_RANGE_O,
   input wire logic [6:0] PRESCALE_P_O,
   input wire logic [4:0] MULTIPLY_N_O,
   input wire logic [7:0] DIVIDE_R_O,
   input wire logic [2:0] IRG_PREDIV_O,
   input wire logic LOSS_IRQ_O,
   input wire logic LOSS_RESET_REQ_O
);
   default clocking cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (!RST_B_I);
   // Prescale is tied to the range actually applied
   chk_prescale_range: assert property (PRESCALE_P_O == (OSC_HIGH_RANGE_O ? 7'h01 : 7'h40))
      else $error("prescale does not follow range");
   // Two quiet cycles tolerate the registered mode decode
   chk_range_ext_only: assert property ((!ACTIVE_MODE_O[1] && !$past(ACTIVE_MODE_O[1])) |-> !OSC_HIGH_RANGE_O)
      else $error("high range outside external modes");
   // Entry to bypass mode only behind a ready reference
   chk_bypass_wait: assert property (($changed(ACTIVE_MODE_O) && ACTIVE_MODE_O == 2'h2) |-> $past(EXT_REFERENCE_READY_I, 2))
      else $error("bypass mode entered without ready reference");
   chk_mult_legal: assert property (!MULTIPLY_N_O[0] && MULTIPLY_N_O >= 5'h04 && MULTIPLY_N_O <= 5'h12)
      else $error("multiply factor outside its table");
   chk_div_onehot: assert property ($onehot(DIVIDE_R_O))
      else $error("divide factor not a power of two");
   chk_prediv_seven: assert property (IRG_PREDIV_O == 3'h7)
      else $error("internal reference predivider not seven");
   // A loss request only appears behind a filtered loss event
   chk_loss_split: assert property ($rose(LOSS_IRQ_O || LOSS_RESET_REQ_O) |->
      $past(LOCK_LOSS_EVENT_I || CLOCK_LOSS_EVENT_I, 6))
      else $error("loss request without a loss event");
   // Nothing can be written in the first cycles, so mode must hold
   chk_reset_scm: assert property ($rose(RST_B_I) |-> (ACTIVE_MODE_O == 2'h0) [*4])
      else $error("not self-clocked after reset");
endmodule
bind cgmc_top cgmc_sva u_sva (.*);
`default_nettype wire

// ==== dv/clock_generator_mode_control_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cgmc_defs.vh"
module clock_generator_mode_control_bench;
   // ********
   // Signals carry the port names so the instance connects by name
   // ********
   logic CORE_CLK_I, RST_B_I, LOCK_I, LOCK_LOSS_EVENT_I, CLOCK_LOSS_EVENT_I, OFF_MODE_I, ENABLE_I;
   logic [3:0] S_AXI_AWADDR_I, S_AXI_WSTRB_I, S_AXI_ARADDR_I;
   logic [31:0] S_AXI_WDATA_I, S_AXI_RDATA_O;
   logic S_AXI_AWVALID_I, S_AXI_AWREADY_O, S_AXI_WVALID_I, S_AXI_WREADY_O, S_AXI_BVALID_O;
   logic S_AXI_BREADY_I, S_AXI_ARVALID_I, S_AXI_ARREADY_O, S_AXI_RVALID_O, S_AXI_RREADY_I;
   logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, ACTIVE_MODE_O;
   logic EXT_REFERENCE_READY_I, HIGH_GAIN_SELECT_O, OSC_HIGH_RANGE_O, REFERENCE_SOURCE_SELECT_O;
   logic OSC_ENABLE_O, CLOCK_LOSS_DETECT_EN_O, LOSS_IRQ_O, LOSS_RESET_REQ_O;
   logic [6:0] PRESCALE_P_O;
   logic [4:0] MULTIPLY_N_O;
   logic [7:0] DIVIDE_R_O, OSCILLATOR_TRIM_O, v;
   logic [2:0] IRG_PREDIV_O;
   logic [31:0] rd;
   logic [1:0] resp;
   int num_errors = 0;
   int comparisons = 0;
   int seed = 17;
   cgmc_top u_dut (.*);
   cgmc_ref_osc u_osc (.clk_i(CORE_CLK_I), .rst_b_i(RST_B_I), .osc_req_i(REFERENCE_SOURCE_SELECT_O),
      .ready_o(EXT_REFERENCE_READY_I));
   // Free-running core clock
   initial begin
      CORE_CLK_I = 1'b0;
      forever #10 CORE_CLK_I = ~CORE_CLK_I;
   end
   // Expected multiply and divide factors, straight from the code tables
   logic [4:0] n_tab [8] = '{5'h04, 5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h10, 5'h12};
   logic [7:0] r_tab [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
   function automatic logic [12:0] exp_nr(input logic [7:0] c);
      return {n_tab[c[6:4]], r_tab[c[2:0]]};
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge CORE_CLK_I);
   endtask
   // Leading edge keeps back-to-back calls from assigning twice at once
   task automatic axi_wr(input logic [3:0] a, input logic [7:0] d);
      bit aw_open, w_open;
      aw_open = 1;
      w_open = 1;
      @(posedge CORE_CLK_I);
      S_AXI_AWADDR_I <= a;
      S_AXI_WDATA_I <= {24'h0, d};
      {S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I} <= 3'h7;
      while (aw_open || w_open) begin
         @(posedge CORE_CLK_I);
         if (aw_open && S_AXI_AWREADY_O === 1'b1) begin
            aw_open = 0;
            S_AXI_AWVALID_I <= 1'b0;
         end
         if (w_open && S_AXI_WREADY_O === 1'b1) begin
            w_open = 0;
            S_AXI_WVALID_I <= 1'b0;
         end
      end
      do @(posedge CORE_CLK_I); while (S_AXI_BVALID_O !== 1'b1);
      resp = S_AXI_BRESP_O;
      S_AXI_BREADY_I <= 1'b0;
   endtask
   task automatic axi_rd(input logic [3:0] a);
      @(posedge CORE_CLK_I);
      S_AXI_ARADDR_I <= a;
      {S_AXI_ARVALID_I, S_AXI_RREADY_I} <= 2'h3;
      do @(posedge CORE_CLK_I); while (S_AXI_ARREADY_O !== 1'b1);
      S_AXI_ARVALID_I <= 1'b0;
      do @(posedge CORE_CLK_I); while (S_AXI_RVALID_O !== 1'b1);
      rd = S_AXI_RDATA_O;
      S_AXI_RREADY_I <= 1'b0;
   endtask
   task automatic wait_mode(input logic [1:0] m);
      for (int i = 0; i < 120 && ACTIVE_MODE_O !== m; i++) @(posedge CORE_CLK_I);
   endtask
   task automatic do_reset;
      RST_B_I <= 1'b0;
      tick(8);
      RST_B_I <= 1'b1;
      tick(2);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Watchdog cuts a hang well past the expected run length
   initial begin
      repeat (20000) @(posedge CORE_CLK_I);
      num_errors++;
      tally_and_finish;
   end
   // ********
   // Main sequence
   // ********
   initial begin
      RST_B_I = 1'b0;
      {S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I, S_AXI_ARVALID_I, S_AXI_RREADY_I} = '0;
      {S_AXI_AWADDR_I, S_AXI_ARADDR_I, S_AXI_WDATA_I} = '0;
      S_AXI_WSTRB_I = 4'hF;
      {LOCK_I, LOCK_LOSS_EVENT_I, CLOCK_LOSS_EVENT_I, OFF_MODE_I, ENABLE_I} = '0;
      do_reset;
      axi_rd(`CGMC_ADDR_CTRL1);
      check(rd, 32'h0);
      check({ACTIVE_MODE_O, PRESCALE_P_O, MULTIPLY_N_O, DIVIDE_R_O}, {2'h0, 7'h40, 5'h04, 8'h01});
      // Strobe without byte zero must leave control one untouched
      S_AXI_WSTRB_I <= 4'hE;
      axi_wr(`CGMC_ADDR_CTRL1, 8'hFF);
      check(resp, `CGMC_RESP_OKAY);
      S_AXI_WSTRB_I <= 4'hF;
      axi_rd(`CGMC_ADDR_CTRL1);
      check(rd, 32'h0);
      v = $random(seed);
      axi_wr(`CGMC_ADDR_TRIM, v);
      axi_rd(`CGMC_ADDR_TRIM);
      check({rd, OSCILLATOR_TRIM_O}, {24'h0, v, v});
      $display("test reset and trim done");
      axi_wr(`CGMC_ADDR_CTRL1, 8'h29);
      axi_rd(`CGMC_ADDR_CTRL1);
      check(rd, 32'h28);
      wait_mode(`CGMC_MODE_FEI);
      check({ACTIVE_MODE_O, REFERENCE_SOURCE_SELECT_O, PRESCALE_P_O}, {2'h1, 1'b1, 7'h40});
      // Every factor code first, then random ones
      for (int i = 0; i < 16; i++) begin
         v = (i < 8) ? {1'b0, i[2:0], 1'b0, ~i[2:0]} : $random(seed) & 8'h77;
         axi_wr(`CGMC_ADDR_CTRL2, v);
         axi_rd(`CGMC_ADDR_CTRL2);
         check({rd, MULTIPLY_N_O, DIVIDE_R_O}, {24'h0, v, exp_nr(v)});
      end
      axi_wr(`CGMC_ADDR_CTRL2, 8'h31);
      tick(3);
      check({MULTIPLY_N_O, DIVIDE_R_O}, {5'h0A, 8'h02});
      LOCK_I <= 1'b1;
      LOCK_LOSS_EVENT_I <= 1'b1;
      tick(8);
      LOCK_LOSS_EVENT_I <= 1'b0;
      tick(4);
      axi_rd(`CGMC_ADDR_STAT1);
      check({rd[4], LOSS_IRQ_O, LOSS_RESET_REQ_O}, 3'b110);
      axi_wr(`CGMC_ADDR_STAT1, 8'h01);
      axi_rd(`CGMC_ADDR_STAT1);
      check({rd[4], LOSS_IRQ_O}, 2'b00);
      axi_wr(`CGMC_ADDR_CTRL2, 8'h08);
      CLOCK_LOSS_EVENT_I <= 1'b1;
      tick(8);
      CLOCK_LOSS_EVENT_I <= 1'b0;
      tick(4);
      check({LOSS_IRQ_O, LOSS_RESET_REQ_O}, 2'b01);
      axi_wr(`CGMC_ADDR_STAT1, 8'h01);
      $display("test factors and loss flags done");
      // Range, source and upper mode bit are all locked by now
      axi_wr(`CGMC_ADDR_CTRL1, 8'h58);
      tick(6);
      axi_rd(`CGMC_ADDR_CTRL1);
      check({rd[6:3], ACTIVE_MODE_O}, {4'b0101, 2'h1});
      axi_wr(`CGMC_ADDR_CTRL1, 8'h82);
      wait_mode(`CGMC_MODE_SCM);
      check({ACTIVE_MODE_O, HIGH_GAIN_SELECT_O, CLOCK_LOSS_DETECT_EN_O}, 4'b0010);
      $display("test write-once locks done");
      do_reset;
      axi_wr(`CGMC_ADDR_CTRL1, 8'h70);
      axi_wr(`CGMC_ADDR_CTRL1, 8'h68);
      axi_rd(`CGMC_ADDR_CTRL1);
      check({rd[4:3], ACTIVE_MODE_O, EXT_REFERENCE_READY_I}, 5'b10000);
      wait_mode(`CGMC_MODE_FBE);
      tick(2);
      check({ACTIVE_MODE_O, OSC_HIGH_RANGE_O, PRESCALE_P_O, OSC_ENABLE_O}, {2'h2, 1'b1, 7'h01, 1'b1});
      OFF_MODE_I <= 1'b1;
      tick(8);
      check(OSC_ENABLE_O, 1'b0);
      ENABLE_I <= 1'b1;
      tick(8);
      check(OSC_ENABLE_O, 1'b1);
      axi_rd(`CGMC_ADDR_CTRL1);
      check(rd[4:3], 2'b10);
      {OFF_MODE_I, ENABLE_I} <= 2'b00;
      axi_wr(`CGMC_ADDR_CTRL1, 8'h7C);
      wait_mode(`CGMC_MODE_FEE);
      check(ACTIVE_MODE_O, 2'h3);
      OFF_MODE_I <= 1'b1;
      tick(8);
      axi_rd(`CGMC_ADDR_CTRL1);
      check({rd[4:3], OSC_ENABLE_O}, 3'b111);
      $display("test external modes done");
      tally_and_finish;
   end
endmodule
`default_nettype wire

// ==== rtl/cgmc_top.v ====
`timescale 1ns/10ps
`default_nettype none
`include "cgmc_defs.vh"
module cgmc_top (
   // Clock and reset
   input wire CORE_CLK_I,
   input wire RST_B_I,
   // AXI4-Lite write address
   input wire [3:0] S_AXI_AWADDR_I,
   input wire S_AXI_AWVALID_I,
   output reg S_AXI_AWREADY_O,
   // AXI4-Lite write data
   input wire [31:0] S_AXI_WDATA_I,
   input wire [3:0] S_AXI_WSTRB_I,
   input wire S_AXI_WVALID_I,
   output reg S_AXI_WREADY_O,
   // AXI4-Lite write response
   output reg [1:0] S_AXI_BRESP_O,
   output reg S_AXI_BVALID_O,
   input wire S_AXI_BREADY_I,
   // AXI4-Lite read address
   input wire [3:0] S_AXI_ARADDR_I,
   input wire S_AXI_ARVALID_I,
   output reg S_AXI_ARREADY_O,
   // AXI4-Lite read data
   output reg [31:0] S_AXI_RDATA_O,
   output reg [1:0] S_AXI_RRESP_O,
   output reg S_AXI_RVALID_O,
   input wire S_AXI_RREADY_I,
   // Analog and loop status
   input wire EXT_REFERENCE_READY_I,
   input wire LOCK_I,
   input wire LOCK_LOSS_EVENT_I,
   input wire CLOCK_LOSS_EVENT_I,
   input wire OFF_MODE_I,
   input wire ENABLE_I,
   // Generator controls
   output reg HIGH_GAIN_SELECT_O,
   output reg OSC_HIGH_RANGE_O,
   output reg [6:0] PRESCALE_P_O,
   output reg REFERENCE_SOURCE_SELECT_O,
   output reg [1:0] ACTIVE_MODE_O,
   output reg OSC_ENABLE_O,
   output reg CLOCK_LOSS_DETECT_EN_O,
   output reg [4:0] MULTIPLY_N_O,
   output reg [7:0] DIVIDE_R_O,
   output reg [7:0] OSCILLATOR_TRIM_O,
   output reg [2:0] IRG_PREDIV_O,
   output reg LOSS_IRQ_O,
   output reg LOSS_RESET_REQ_O
);

   // ****************************************
   // Input synchronisers
   // ****************************************
   reg [5:0] sync1;
   reg [5:0] sync2;
   reg [5:0] sync3;
   reg [5:0] stable;
   wire [5:0] raw_in;
   assign raw_in = {LOCK_I, ENABLE_I, OFF_MODE_I, CLOCK_LOSS_EVENT_I, LOCK_LOSS_EVENT_I,
      EXT_REFERENCE_READY_I};
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
         // Change accepted once stages two and three agree
         always @(posedge CORE_CLK_I or negedge RST_B_I) begin
            if (!RST_B_I) begin
               sync1[gi] <= 1'b0;
               sync2[gi] <= 1'b0;
               sync3[gi] <= 1'b0;
               stable[gi] <= 1'b0;
            end else begin
               sync1[gi] <= raw_in[gi];
               sync2[gi] <= sync1[gi];
               sync3[gi] <= sync2[gi];
               if (sync2[gi] == sync3[gi]) begin
                  stable[gi] <= sync3[gi];
               end
            end
         end
      end
   endgenerate
   // Lock status shares the filtered path, so a one-cycle glitch never reaches status
   wire lock_in = stable[5];
   wire ext_reference_ready = stable[0];
   wire lol_lvl = stable[1];
   wire loc_lvl = stable[2];
   wire off_mode = stable[3];
   wire enable_in = stable[4];
   reg lol_prev;
   reg loc_prev;

   // ****************************************
   // Register state
   // ****************************************
   reg [7:0] ctrl1;
   reg [7:0] ctrl2;
   reg [7:0] trim;
   reg range_written;
   reg reference_source_select_written;
   reg mode_written;
   reg ext_blocked;
   reg [1:0] active_mode;
   reg lock_loss_status;
   reg clock_loss_status;
   reg intf;
   reg ctrl2_pending;

   // ****************************************
   // AXI4-Lite slave
   // ****************************************
   reg aw_held;
   reg w_held;
   reg [3:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire do_write = aw_held && w_held && !S_AXI_BVALID_O;
   wire wr_lane0 = w_strb[0];
   wire [7:0] wb = w_data[7:0];
   wire mode_pending = (ctrl1[4:3] != active_mode);
   wire wr_c1 = do_write && wr_lane0 && (aw_addr == `CGMC_ADDR_CTRL1);
   wire wr_c2 = do_write && wr_lane0 && (aw_addr == `CGMC_ADDR_CTRL2);
   wire wr_s1 = do_write && wr_lane0 && (aw_addr == `CGMC_ADDR_STAT1);
   wire wr_tr = do_write && wr_lane0 && (aw_addr == `CGMC_ADDR_TRIM);
   wire lol_rise = lol_lvl && !lol_prev;
   wire loc_rise = loc_lvl && !loc_prev && !ctrl1[`CGMC_C1_CLOCK_LOSS_DETECT_DISABLE];
   wire wr_known = (aw_addr == `CGMC_ADDR_CTRL1) || (aw_addr == `CGMC_ADDR_CTRL2) ||
      (aw_addr == `CGMC_ADDR_STAT1) || (aw_addr == `CGMC_ADDR_TRIM);
   // Address and data taken in either order, one write at a time
   always @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         S_AXI_AWREADY_O <= 1'b0;
         S_AXI_WREADY_O <= 1'b0;
         S_AXI_BVALID_O <= 1'b0;
         S_AXI_BRESP_O <= `CGMC_RESP_OKAY;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
      end else begin
         S_AXI_AWREADY_O <= !aw_held && !S_AXI_AWREADY_O && !S_AXI_BVALID_O;
         S_AXI_WREADY_O <= !w_held && !S_AXI_WREADY_O && !S_AXI_BVALID_O;
         if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            aw_held <= 1'b1;
            aw_addr <= {S_AXI_AWADDR_I[3:2], 2'h0};
            S_AXI_AWREADY_O <= 1'b0;
         end
         if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA_I;
            w_strb <= S_AXI_WSTRB_I;
            S_AXI_WREADY_O <= 1'b0;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            S_AXI_BVALID_O <= 1'b1;
            S_AXI_BRESP_O <= wr_known ? `CGMC_RESP_OKAY : `CGMC_RESP_SLVERR;
         end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
            S_AXI_BVALID_O <= 1'b0;
         end
      end
   end

   // Read path, one read at a time
   wire [7:0] stat1 = {active_mode, ctrl1[`CGMC_C1_REFERENCE_SOURCE_SELECT], lock_loss_status, lock_in, clock_loss_status, ext_reference_ready, intf};
   always @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         S_AXI_ARREADY_O <= 1'b0;
         S_AXI_RVALID_O <= 1'b0;
         S_AXI_RDATA_O <= 32'h0;
         S_AXI_RRESP_O <= `CGMC_RESP_OKAY;
      end else begin
         S_AXI_ARREADY_O <= !S_AXI_ARREADY_O && !S_AXI_RVALID_O;
         if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O <= 1'b1;
            S_AXI_RRESP_O <= `CGMC_RESP_OKAY;
            case ({S_AXI_ARADDR_I[3:2], 2'h0})
               // R15: bit zero reads zero
               `CGMC_ADDR_CTRL1: S_AXI_RDATA_O <= {24'h0, ctrl1[7:1], 1'b0};
               `CGMC_ADDR_CTRL2: S_AXI_RDATA_O <= {24'h0, ctrl2};
               `CGMC_ADDR_STAT1: S_AXI_RDATA_O <= {24'h0, stat1};
               `CGMC_ADDR_TRIM: S_AXI_RDATA_O <= {24'h0, trim};
               default: begin
                  S_AXI_RDATA_O <= 32'h0;
                  S_AXI_RRESP_O <= `CGMC_RESP_SLVERR;
               end
            endcase
         end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
            S_AXI_RVALID_O <= 1'b0;
         end
      end
   end

   // ****************************************
   // Control registers
   // ****************************************
   // Write-once and interlock handling of control one
   always @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         // R17: reset lands in self-clocked
         ctrl1 <= `CGMC_RST_CTRL1;
         ctrl2 <= `CGMC_RST_CTRL2;
         trim <= `CGMC_RST_TRIM;
         range_written <= 1'b0;
         reference_source_select_written <= 1'b0;
         mode_written <= 1'b0;
         ext_blocked <= 1'b0;
         ctrl2_pending <= 1'b0;
      end else begin
         if (wr_c1) begin
            ctrl1[`CGMC_C1_HGO] <= wb[`CGMC_C1_HGO];
            ctrl1[`CGMC_C1_OSCEN] <= wb[`CGMC_C1_OSCEN];
            ctrl1[`CGMC_C1_CLOCK_LOSS_DETECT_DISABLE] <= wb[`CGMC_C1_CLOCK_LOSS_DETECT_DISABLE];
            // R3: range only first write
            if (!range_written) begin
               ctrl1[`CGMC_C1_RANGE] <= wb[`CGMC_C1_RANGE];
               range_written <= 1'b1;
            end
            // R6: source select write-once
            if (!reference_source_select_written) begin
               ctrl1[`CGMC_C1_REFERENCE_SOURCE_SELECT] <= wb[`CGMC_C1_REFERENCE_SOURCE_SELECT];
               reference_source_select_written <= 1'b1;
            end
            // R10 R11: pending change and first-write lockout
            if (!mode_pending && !(ext_blocked && wb[`CGMC_C1_MODE_HI])) begin
               ctrl1[4:3] <= wb[4:3];
            end
            if (!mode_written) begin
               mode_written <= 1'b1;
               ext_blocked <= !wb[`CGMC_C1_MODE_HI];
            end
         end
         // Factor writes are dropped in the cycle right after a prior factor write
         if (wr_c2 && !ctrl2_pending) begin
            ctrl2 <= wb;
            ctrl2_pending <= 1'b1;
         end else begin
            ctrl2_pending <= 1'b0;
         end
         // R22: trim held as software wrote it
         if (wr_tr) begin
            trim <= wb;
         end
      end
   end

   // ****************************************
   // Mode sequencing and loss flags
   // ****************************************
   // R9: off mode does not touch ctrl1
   always @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         active_mode <= `CGMC_MODE_SCM;
         lock_loss_status <= 1'b0;
         clock_loss_status <= 1'b0;
         intf <= 1'b0;
         lol_prev <= 1'b0;
         loc_prev <= 1'b0;
      end else begin
         lol_prev <= lol_lvl;
         loc_prev <= loc_lvl;
         // R7 R8: bypassed waits for ready
         if (ctrl1[4:3] != `CGMC_MODE_FBE || ext_reference_ready) begin
            active_mode <= ctrl1[4:3];
         end
         // R26 R21: set wins over software clear
         if (lol_rise) begin
            lock_loss_status <= 1'b1;
         end else if (wr_s1 && wb[`CGMC_S1_IF]) begin
            lock_loss_status <= 1'b0;
         end
         if (loc_rise) begin
            clock_loss_status <= 1'b1;
         end else if (wr_s1 && wb[`CGMC_S1_IF]) begin
            clock_loss_status <= 1'b0;
         end
         if (lol_rise || loc_rise) begin
            intf <= 1'b1;
         end else if (wr_s1 && wb[`CGMC_S1_IF]) begin
            intf <= 1'b0;
         end
      end
   end

   // ****************************************
   // Generator outputs
   // ****************************************
   wire ext_mode = active_mode[1];
   wire [2:0] multiply_factor = ctrl2[`CGMC_C2_MFD_HI:`CGMC_C2_MFD_LO];
   wire [2:0] output_divide_factor = ctrl2[`CGMC_C2_RFD_HI:`CGMC_C2_RFD_LO];
   reg next_osc;
   // R12 R13: oscillator state in off mode
   always @* begin
      if (!off_mode) begin
         next_osc = ctrl1[`CGMC_C1_REFERENCE_SOURCE_SELECT] && ext_mode;
      end else if (ctrl1[`CGMC_C1_OSCEN]) begin
         next_osc = ctrl1[`CGMC_C1_MODE_HI] && ctrl1[`CGMC_C1_REFERENCE_SOURCE_SELECT];
      end else begin
         next_osc = enable_in && (ctrl1[4:3] == `CGMC_MODE_FBE) && ctrl1[`CGMC_C1_REFERENCE_SOURCE_SELECT];
      end
   end
   // Registered outputs
   always @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         HIGH_GAIN_SELECT_O <= 1'b0;
         OSC_HIGH_RANGE_O <= 1'b0;
         PRESCALE_P_O <= `CGMC_P_LOW;
         REFERENCE_SOURCE_SELECT_O <= 1'b0;
         ACTIVE_MODE_O <= `CGMC_MODE_SCM;
         OSC_ENABLE_O <= 1'b0;
         CLOCK_LOSS_DETECT_EN_O <= 1'b1;
         MULTIPLY_N_O <= 5'h04;
         DIVIDE_R_O <= 8'h01;
         OSCILLATOR_TRIM_O <= `CGMC_RST_TRIM;
         IRG_PREDIV_O <= `CGMC_IRG_DIV;
         LOSS_IRQ_O <= 1'b0;
         LOSS_RESET_REQ_O <= 1'b0;
      end else begin
         // R1: gain select
         HIGH_GAIN_SELECT_O <= ctrl1[`CGMC_C1_HGO];
         // R2 R4: range and P only in external modes, P=64 otherwise
         OSC_HIGH_RANGE_O <= ext_mode && ctrl1[`CGMC_C1_RANGE];
         PRESCALE_P_O <= (ext_mode && ctrl1[`CGMC_C1_RANGE]) ? `CGMC_P_HIGH : `CGMC_P_LOW;
         // R5: source request
         REFERENCE_SOURCE_SELECT_O <= ctrl1[`CGMC_C1_REFERENCE_SOURCE_SELECT];
         ACTIVE_MODE_O <= active_mode;
         OSC_ENABLE_O <= next_osc;
         // R14: detection disable
         CLOCK_LOSS_DETECT_EN_O <= !ctrl1[`CGMC_C1_CLOCK_LOSS_DETECT_DISABLE];
         // R20 R24: N = 4 + 2 * code
         MULTIPLY_N_O <= 5'h04 + {1'b0, multiply_factor, 1'b0};
         // R25: R = 2 ** code
         DIVIDE_R_O <= 8'h01 << output_divide_factor;
         OSCILLATOR_TRIM_O <= trim;
         // R16: internal reference predivided by 7
         IRG_PREDIV_O <= `CGMC_IRG_DIV;
         // R18 R19: interrupt or reset per enable
         LOSS_IRQ_O <= (lock_loss_status && !ctrl2[`CGMC_C2_LOCK_LOSS_RESET_ENABLE]) || (clock_loss_status && !ctrl2[`CGMC_C2_CLOCK_LOSS_RESET_ENABLE]);
         LOSS_RESET_REQ_O <= (lock_loss_status && ctrl2[`CGMC_C2_LOCK_LOSS_RESET_ENABLE]) || (clock_loss_status && ctrl2[`CGMC_C2_CLOCK_LOSS_RESET_ENABLE]);
      end
   end

endmodule
`default_nettype wire
